/* verilog/clock_ctrl_pkg.sv */
`default_nettype none
package clock_ctrl_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] REFDIV_IDX = 12'h010;
  localparam logic [11:0] OUTLOOP_IDX = 12'h011;
  localparam logic [11:0] STATUS_IDX = 12'h012;
  localparam logic [11:0] MISC_IDX = 12'h01c;
  localparam logic [11:0] VCOCTL_IDX = 12'h0f3;
  // misc control fields
  localparam int MODE_LSB = 0;
  localparam int MAN_SEL_BIT = 2;
  localparam int CP_MID_BIT = 6;
  localparam int INDEP_BIT = 7;
  localparam logic [1:0] MODE_MAN_REG = 2'h0;
  localparam logic [1:0] MODE_MAN_PIN = 2'h1;
  localparam logic [1:0] MODE_NONREV = 2'h2;
  localparam logic [1:0] MODE_REVERT = 2'h3;
  // vco control fields
  localparam int CAL_BIT = 1;
  // reference divider fields
  localparam int DIVA_LSB = 0;
  localparam int DIVB_LSB = 16;
  // output loop fields
  localparam int BCNT_LSB = 0;
  localparam int ACNT_LSB = 8;
  localparam int VDIV_LSB = 16;
  localparam int DBL_BIT = 24;
  // reset values
  localparam logic [31:0] REFDIV_RST = 32'h0001_0001;
  localparam logic [31:0] OUTLOOP_RST = 32'h0004_0004;
  localparam logic [31:0] MISC_RST = 32'h0000_0000;
  localparam logic [31:0] VCOCTL_RST = 32'h0000_0000;
  // divider limits
  localparam logic [9:0] REF_DIV_MIN = 10'h001;
  localparam logic [3:0] VCO_DIV_MIN = 4'h4;
  localparam logic [3:0] VCO_DIV_MAX = 4'hb;
  localparam logic [5:0] BCNT_MIN = 6'h04;
  localparam logic [9:0] PRESCALE = 10'h004;
  // timing in oscillator_input cycles
  localparam logic [10:0] LOSS_OSC_CYCLES = 11'h400;
  localparam logic [7:0] CAL_OSC_CYCLES = 8'h80;

  typedef enum logic [2:0] {
    ST_PRIMARY = 3'b001,
    ST_SECONDARY = 3'b010,
    ST_HOLDOVER = 3'b100
  } sel_state_type;

  typedef struct packed {
    logic primary;
    logic secondary;
  } ref_status_type;

  typedef struct packed {
    logic doubler;
    logic [3:0] vco_div;
    logic [1:0] swallow;
    logic [5:0] coarse;
  } outloop_cfg_type;
endpackage
`default_nettype wire

/* verilog/tick_divider.sv */
`default_nettype none
// divides a stream of one-cycle ticks by ratio, emitting one pulse per ratio ticks
module tick_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic [9:0] ratio,
  output logic pulse
);
  logic [9:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 10'h000;
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (tick) begin
        if (cnt_r >= ratio - 10'h001) begin
          cnt_r <= 10'h000;
          pulse <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 10'h001;
        end
      end
    end
  end
endmodule // tick_divider
`default_nettype wire

/* verilog/reference_switchover_and_dividers.sv */
`default_nettype none
module reference_switchover_and_dividers (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic primary_reference,
  input wire logic secondary_reference,
  input wire logic oscillator_input,
  input wire logic vco_clock,
  input wire logic reference_select_pin,
  output logic input_loop_pfd_ref,
  output logic input_loop_pfd_fb,
  output logic output_loop_pfd_ref,
  output logic output_loop_pfd_fb,
  output logic vco_div_pulse,
  output logic secondary_active,
  output logic holdover,
  output logic cp_tristate,
  output logic cp_half_supply,
  output logic cal_busy
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [3:0] pin_s3_r;
  logic [3:0] rise;
  logic osc_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      pin_s3_r <= 4'h0;
    end else begin
      pin_s1_r <= {reference_select_pin, vco_clock, oscillator_input,
                   secondary_reference, primary_reference};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r[3:0];
    end
  end

  assign rise = pin_s2_r[3:0] & ~pin_s3_r;
  assign osc_fall = ~pin_s2_r[2] & pin_s3_r[2];

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] refdiv_r;
  logic [31:0] outloop_r;
  logic [31:0] misc_r;
  logic [31:0] vcoctl_r;
  logic [11:0] idx;
  logic wr_en;
  logic map_hit;
  logic [31:0] rd_val;
  logic [31:0] status_val;

  assign idx = paddr[13:2];
  assign wr_en = psel & penable & pwrite;
  assign map_hit = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0) &&
                   (idx == clock_ctrl_pkg::REFDIV_IDX || idx == clock_ctrl_pkg::OUTLOOP_IDX ||
                    idx == clock_ctrl_pkg::STATUS_IDX || idx == clock_ctrl_pkg::MISC_IDX ||
                    idx == clock_ctrl_pkg::VCOCTL_IDX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refdiv_r <= clock_ctrl_pkg::REFDIV_RST;
      outloop_r <= clock_ctrl_pkg::OUTLOOP_RST;
      misc_r <= clock_ctrl_pkg::MISC_RST;
      vcoctl_r <= clock_ctrl_pkg::VCOCTL_RST;
    end else if (wr_en && map_hit) begin
      unique case (idx)
        clock_ctrl_pkg::REFDIV_IDX: refdiv_r <= pwdata & 32'h03ff_03ff;
        clock_ctrl_pkg::OUTLOOP_IDX: outloop_r <= pwdata & 32'h010f_033f;
        clock_ctrl_pkg::MISC_IDX: misc_r <= pwdata & 32'h0000_00c7;
        clock_ctrl_pkg::VCOCTL_IDX: vcoctl_r <= pwdata & 32'h0000_0002;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (idx)
      clock_ctrl_pkg::REFDIV_IDX: rd_val = refdiv_r;
      clock_ctrl_pkg::OUTLOOP_IDX: rd_val = outloop_r;
      clock_ctrl_pkg::STATUS_IDX: rd_val = status_val;
      clock_ctrl_pkg::MISC_IDX: rd_val = misc_r;
      clock_ctrl_pkg::VCOCTL_IDX: rd_val = vcoctl_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // read data and error captured in the setup phase, zero-wait access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata <= (map_hit && !pwrite) ? rd_val : 32'h0000_0000;
        pslverr <= !map_hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference dividers
  function automatic logic [9:0] ref_ratio(input logic [9:0] v);
    ref_ratio = (v < clock_ctrl_pkg::REF_DIV_MIN) ? clock_ctrl_pkg::REF_DIV_MIN : v;
  endfunction

  logic [9:0] div_a_ratio;
  logic [9:0] div_b_ratio;
  logic div_a_pulse;
  logic div_b_pulse;

  assign div_a_ratio = ref_ratio(refdiv_r[clock_ctrl_pkg::DIVA_LSB +: 10]);
  assign div_b_ratio = misc_r[clock_ctrl_pkg::INDEP_BIT] ?
                       ref_ratio(refdiv_r[clock_ctrl_pkg::DIVB_LSB +: 10]) : div_a_ratio;

  tick_divider u_div_a (
    .pclk(pclk),
    .presetn(presetn),
    .tick(rise[0]),
    .ratio(div_a_ratio),
    .pulse(div_a_pulse)
  );

  tick_divider u_div_b (
    .pclk(pclk),
    .presetn(presetn),
    .tick(rise[1]),
    .ratio(div_b_ratio),
    .pulse(div_b_pulse)
  );

  ////////////////////////////////////////////////////////////////////////
  // reference monitor
  logic [10:0] gap_a_r;
  logic [10:0] gap_b_r;
  clock_ctrl_pkg::ref_status_type present_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_a_r <= 11'h000;
      gap_b_r <= 11'h000;
      present_r <= '0;
    end else begin
      if (div_a_pulse) begin
        gap_a_r <= 11'h000;
        present_r.primary <= 1'b1;
      end else if (rise[2]) begin
        if (gap_a_r == clock_ctrl_pkg::LOSS_OSC_CYCLES - 11'h001) begin
          present_r.primary <= 1'b0;
        end else begin
          gap_a_r <= gap_a_r + 11'h001;
        end
      end
      if (div_b_pulse) begin
        gap_b_r <= 11'h000;
        present_r.secondary <= 1'b1;
      end else if (rise[2]) begin
        if (gap_b_r == clock_ctrl_pkg::LOSS_OSC_CYCLES - 11'h001) begin
          present_r.secondary <= 1'b0;
        end else begin
          gap_b_r <= gap_b_r + 11'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // switchover control
  clock_ctrl_pkg::sel_state_type state_r;
  clock_ctrl_pkg::sel_state_type state_nxt;
  logic [1:0] mode;
  logic man_sec;
  logic pa;
  logic pb;

  assign mode = misc_r[clock_ctrl_pkg::MODE_LSB +: 2];
  assign man_sec = (mode == clock_ctrl_pkg::MODE_MAN_PIN) ? pin_s2_r[4] :
                   misc_r[clock_ctrl_pkg::MAN_SEL_BIT];
  assign pa = present_r.primary;
  assign pb = present_r.secondary;

  always_comb begin
    state_nxt = state_r;
    if (!pa && !pb) begin
      state_nxt = clock_ctrl_pkg::ST_HOLDOVER;
    end else if (mode == clock_ctrl_pkg::MODE_MAN_REG || mode == clock_ctrl_pkg::MODE_MAN_PIN) begin
      state_nxt = man_sec ? clock_ctrl_pkg::ST_SECONDARY : clock_ctrl_pkg::ST_PRIMARY;
    end else begin
      unique case (state_r)
        clock_ctrl_pkg::ST_PRIMARY: begin
          if (!pa && pb) begin
            state_nxt = clock_ctrl_pkg::ST_SECONDARY;
          end
        end
        clock_ctrl_pkg::ST_SECONDARY: begin
          if (mode == clock_ctrl_pkg::MODE_REVERT && pa) begin
            state_nxt = clock_ctrl_pkg::ST_PRIMARY;
          end else if (!pb && pa) begin
            state_nxt = clock_ctrl_pkg::ST_PRIMARY;
          end
        end
        clock_ctrl_pkg::ST_HOLDOVER: begin
          state_nxt = pa ? clock_ctrl_pkg::ST_PRIMARY : clock_ctrl_pkg::ST_SECONDARY;
        end
        default: state_nxt = clock_ctrl_pkg::ST_HOLDOVER;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= clock_ctrl_pkg::ST_HOLDOVER;
    end else begin
      state_r <= state_nxt;
    end
  end

  // selected divided reference and charge pump mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_loop_pfd_ref <= 1'b0;
      input_loop_pfd_fb <= 1'b0;
      secondary_active <= 1'b0;
      holdover <= 1'b1;
      cp_tristate <= 1'b1;
      cp_half_supply <= 1'b0;
    end else begin
      input_loop_pfd_ref <= (state_r == clock_ctrl_pkg::ST_PRIMARY) ? div_a_pulse :
                            (state_r == clock_ctrl_pkg::ST_SECONDARY) ? div_b_pulse : 1'b0;
      input_loop_pfd_fb <= rise[2];
      secondary_active <= (state_r == clock_ctrl_pkg::ST_SECONDARY);
      holdover <= (state_r == clock_ctrl_pkg::ST_HOLDOVER);
      cp_tristate <= (state_r == clock_ctrl_pkg::ST_HOLDOVER) &&
                     !misc_r[clock_ctrl_pkg::CP_MID_BIT];
      cp_half_supply <= (state_r == clock_ctrl_pkg::ST_HOLDOVER) &&
                        misc_r[clock_ctrl_pkg::CP_MID_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output loop: doubler, vco divider, feedback divider
  clock_ctrl_pkg::outloop_cfg_type cfg;
  logic [9:0] fb_cnt_r;
  logic [9:0] vdiv_cnt_r;
  logic [9:0] fb_ratio;
  logic [3:0] vdiv_ratio;
  logic [5:0] coarse;

  assign cfg = {outloop_r[clock_ctrl_pkg::DBL_BIT], outloop_r[clock_ctrl_pkg::VDIV_LSB +: 4],
                outloop_r[clock_ctrl_pkg::ACNT_LSB +: 2], outloop_r[clock_ctrl_pkg::BCNT_LSB +: 6]};
  assign coarse = (cfg.coarse < clock_ctrl_pkg::BCNT_MIN) ? clock_ctrl_pkg::BCNT_MIN : cfg.coarse;
  assign fb_ratio = 10'(clock_ctrl_pkg::PRESCALE * {4'h0, coarse}) + {8'h00, cfg.swallow};
  assign vdiv_ratio = (cfg.vco_div < clock_ctrl_pkg::VCO_DIV_MIN) ? clock_ctrl_pkg::VCO_DIV_MIN :
                      (cfg.vco_div > clock_ctrl_pkg::VCO_DIV_MAX) ? clock_ctrl_pkg::VCO_DIV_MAX :
                      cfg.vco_div;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_cnt_r <= 10'h000;
      vdiv_cnt_r <= 10'h000;
      output_loop_pfd_ref <= 1'b0;
      output_loop_pfd_fb <= 1'b0;
      vco_div_pulse <= 1'b0;
    end else begin
      output_loop_pfd_ref <= rise[2] | (cfg.doubler & osc_fall);
      output_loop_pfd_fb <= 1'b0;
      vco_div_pulse <= 1'b0;
      if (rise[3]) begin
        if (fb_cnt_r >= fb_ratio - 10'h001) begin
          fb_cnt_r <= 10'h000;
          output_loop_pfd_fb <= 1'b1;
        end else begin
          fb_cnt_r <= fb_cnt_r + 10'h001;
        end
        if (vdiv_cnt_r >= {6'h00, vdiv_ratio} - 10'h001) begin
          vdiv_cnt_r <= 10'h000;
          vco_div_pulse <= 1'b1;
        end else begin
          vdiv_cnt_r <= vdiv_cnt_r + 10'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vco calibration
  logic cal_prev_r;
  logic [7:0] cal_cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_prev_r <= 1'b0;
      cal_cnt_r <= 8'h00;
      cal_busy <= 1'b0;
    end else begin
      cal_prev_r <= vcoctl_r[clock_ctrl_pkg::CAL_BIT];
      if (vcoctl_r[clock_ctrl_pkg::CAL_BIT] && !cal_prev_r) begin
        // band search runs on oscillator ticks
        cal_busy <= 1'b1;
        cal_cnt_r <= 8'h00;
      end else if (cal_busy && rise[2]) begin
        if (cal_cnt_r == clock_ctrl_pkg::CAL_OSC_CYCLES - 8'h01) begin
          cal_busy <= 1'b0;
        end else begin
          cal_cnt_r <= cal_cnt_r + 8'h01;
        end
      end
    end
  end

  assign status_val = {26'h0000000, cal_busy, (state_r == clock_ctrl_pkg::ST_HOLDOVER),
                       (state_r == clock_ctrl_pkg::ST_SECONDARY), pb, pa, 1'b0};
endmodule // reference_switchover_and_dividers
`default_nettype wire

/* tb/ref_sources_model.sv */
`default_nettype none
module ref_sources_model (
  input wire logic pclk,
  input wire logic [3:0] run,
  output logic prim_pin,
  output logic sec_pin,
  output logic osc_pin,
  output logic vco_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lvl_r;
  logic [3:0] ph_r;
  ////////////////////////////////////////////////////////////////
  // each source holds two cycles per level, stands low when stopped
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!run[i]) begin
        lvl_r[i] <= 1'b0;
        ph_r[i] <= 1'b0;
      end else begin
        ph_r[i] <= ~ph_r[i];
        if (ph_r[i]) lvl_r[i] <= ~lvl_r[i];
      end
    end
  end
  assign prim_pin = lvl_r[0];
  assign sec_pin = lvl_r[1];
  assign osc_pin = lvl_r[2];
  assign vco_pin = lvl_r[3];
endmodule // ref_sources_model
`default_nettype wire

/* tb/reference_switchover_and_dividers_assertions.sv */
`default_nettype none
module reference_switchover_and_dividers_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic oscillator_input,
  input wire logic input_loop_pfd_ref,
  input wire logic input_loop_pfd_fb,
  input wire logic output_loop_pfd_fb,
  input wire logic vco_div_pulse,
  input wire logic secondary_active,
  input wire logic holdover,
  input wire logic cp_tristate,
  input wire logic cp_half_supply,
  input wire logic cal_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cal_wr;
  assign cal_wr = psel && penable && pwrite && pwdata[clock_ctrl_pkg::CAL_BIT] &&
                  paddr == {2'h0, clock_ctrl_pkg::VCOCTL_IDX, 2'h0};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  sequence s_cal_rise;
    !cal_busy ##1 cal_busy;
  endsequence
  sequence s_hold_steady;
    holdover [*2];
  endsequence
  property p_sec_hold;
    secondary_active |-> !holdover;
  endproperty
  property p_cp_mode;
    holdover |-> (cp_tristate != cp_half_supply);
  endproperty
  property p_cp_off;
    !holdover |-> !cp_tristate && !cp_half_supply;
  endproperty
  property p_hold_no_ref;
    s_hold_steady |-> !input_loop_pfd_ref;
  endproperty
  property p_fb_runs;
    $rose(oscillator_input) |-> ##[2:5] input_loop_pfd_fb;
  endproperty
  property p_vco_gap;
    vco_div_pulse |=> !vco_div_pulse [*8];
  endproperty
  property p_fb_gap;
    output_loop_pfd_fb |=> !output_loop_pfd_fb [*8];
  endproperty
  property p_cal_start;
    s_cal_rise |-> $past(cal_wr, 2);
  endproperty
  a_sec_hold: assert property (p_sec_hold)
    else $error("secondary active during holdover");
  a_cp_mode: assert property (p_cp_mode)
    else $error("charge pump mode wrong in holdover");
  a_cp_off: assert property (p_cp_off)
    else $error("charge pump held outside holdover");
  a_hold_no_ref: assert property (p_hold_no_ref)
    else $error("reference pulse during holdover");
  a_fb_runs: assert property (p_fb_runs)
    else $error("input loop feedback pulse missing");
  a_vco_gap: assert property (p_vco_gap)
    else $error("vco divider pulses too close");
  a_fb_gap: assert property (p_fb_gap)
    else $error("feedback divider pulses too close");
  a_cal_start: assert property (p_cal_start)
    else $error("calibration started without write");
endmodule // reference_switchover_and_dividers_assertions
`default_nettype wire

/* tb/reference_switchover_and_dividers_tb_top.sv */
`default_nettype none
module reference_switchover_and_dividers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, reference_select_pin;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic primary_reference, secondary_reference, oscillator_input, vco_clock;
  logic input_loop_pfd_ref, input_loop_pfd_fb, output_loop_pfd_ref, output_loop_pfd_fb;
  logic vco_div_pulse, secondary_active, holdover, cp_tristate, cp_half_supply, cal_busy;
  logic [3:0] run;
  int n_fail, tests_run, cycles;
  reference_switchover_and_dividers uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .primary_reference, .secondary_reference,
    .oscillator_input, .vco_clock, .reference_select_pin, .input_loop_pfd_ref,
    .input_loop_pfd_fb, .output_loop_pfd_ref, .output_loop_pfd_fb, .vco_div_pulse,
    .secondary_active, .holdover, .cp_tristate, .cp_half_supply, .cal_busy);
  ref_sources_model src (.pclk(pclk), .run(run), .prim_pin(primary_reference),
    .sec_pin(secondary_reference), .osc_pin(oscillator_input), .vco_pin(vco_clock));
  ////////////////////////////////////////////////////////////////
  function automatic logic pick(input int k);
    case (k)
      0: return input_loop_pfd_ref;
      1: return input_loop_pfd_fb;
      2: return output_loop_pfd_ref;
      3: return vco_div_pulse;
      4: return output_loop_pfd_fb;
      5: return secondary_active;
      6: return holdover;
      7: return cal_busy;
      default: return cp_half_supply;
    endcase
  endfunction
  task automatic stop_test();
    $display("tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rchk(input string nm, input logic [11:0] idx, input logic [31:0] exp,
                      input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(nm, r, exp);
    chk({nm, " err"}, {31'h0, e}, {31'h0, exp_err});
  endtask
  task automatic wchk(input string nm, input int k, input logic v, input int lim);
    int t;
    t = 0;
    while (pick(k) !== v && t < lim) begin
      @(negedge pclk);
      t++;
    end
    chk(nm, {31'h0, pick(k)}, {31'h0, v});
  endtask
  // waits for the next pulse, then measures the interval up to the pulse after it
  task automatic gchk(input string nm, input int k, input int exp);
    int n;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (pick(k) !== 1'b1 && n < 9000);
    end
    chk(nm, 32'(n), 32'(exp));
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, reference_select_pin} = 5'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    run = 4'h0;
    {n_fail, tests_run, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge pclk);
    chk("holdover", {31'h0, holdover}, 32'h1);
    chk("cp_tristate", {31'h0, cp_tristate}, 32'h1);
    presetn <= 1'b1;
    run <= 4'b1100;
    rchk("refdiv", clock_ctrl_pkg::REFDIV_IDX, clock_ctrl_pkg::REFDIV_RST, 1'b0);
    rchk("outloop", clock_ctrl_pkg::OUTLOOP_IDX, clock_ctrl_pkg::OUTLOOP_RST, 1'b0);
    rchk("misc", clock_ctrl_pkg::MISC_IDX, clock_ctrl_pkg::MISC_RST, 1'b0);
    rchk("vcoctl", clock_ctrl_pkg::VCOCTL_IDX, clock_ctrl_pkg::VCOCTL_RST, 1'b0);
    rchk("unmapped", 12'h013, 32'h0, 1'b1);
    wreg(clock_ctrl_pkg::REFDIV_IDX, 32'h03ff_03ff);
    rchk("refdiv max", clock_ctrl_pkg::REFDIV_IDX, 32'h03ff_03ff, 1'b0);
    gchk("vco gap", 3, 16);
    gchk("fb gap", 4, 64);
    gchk("outref gap", 2, 4);
    wreg(clock_ctrl_pkg::OUTLOOP_IDX, 32'h010b_033f);
    rchk("outloop max", clock_ctrl_pkg::OUTLOOP_IDX, 32'h010b_033f, 1'b0);
    gchk("vco gap", 3, 44);
    gchk("fb gap", 4, 1020);
    gchk("outref gap", 2, 2);
    wreg(clock_ctrl_pkg::OUTLOOP_IDX, 32'h0000_0000);
    gchk("vco clamp", 3, 16);
    gchk("fb clamp", 4, 64);
    wreg(clock_ctrl_pkg::REFDIV_IDX, 32'h0003_0005);
    wreg(clock_ctrl_pkg::MISC_IDX, 32'h03);
    run <= 4'b1111;
    wchk("holdover", 6, 1'b0, 200);
    chk("sec", {31'h0, secondary_active}, 32'h0);
    rchk("status", clock_ctrl_pkg::STATUS_IDX, 32'h6, 1'b0);
    gchk("ref gap", 0, 20);
    run <= 4'b1110;
    wchk("sec", 5, 1'b1, 5000);
    gchk("ref gap", 0, 20);
    wreg(clock_ctrl_pkg::MISC_IDX, 32'h83);
    gchk("ref gap", 0, 12);
    run <= 4'b1111;
    wchk("sec", 5, 1'b0, 100);
    wreg(clock_ctrl_pkg::MISC_IDX, 32'h82);
    run <= 4'b1110;
    wchk("sec", 5, 1'b1, 5000);
    run <= 4'b1111;
    repeat (200) @(negedge pclk);
    chk("sec", {31'h0, secondary_active}, 32'h1);
    run <= 4'b1101;
    wchk("sec", 5, 1'b0, 5000);
    run <= 4'b1100;
    wchk("holdover", 6, 1'b1, 5000);
    chk("cp_tristate", {31'h0, cp_tristate}, 32'h1);
    gchk("fb gap", 1, 4);
    rchk("status", clock_ctrl_pkg::STATUS_IDX, 32'h10, 1'b0);
    wreg(clock_ctrl_pkg::MISC_IDX, 32'hc2);
    wchk("half", 8, 1'b1, 10);
    run <= 4'b1110;
    wchk("holdover", 6, 1'b0, 100);
    chk("sec", {31'h0, secondary_active}, 32'h1);
    run <= 4'b1111;
    wreg(clock_ctrl_pkg::MISC_IDX, 32'h80);
    wchk("sec", 5, 1'b0, 20);
    wreg(clock_ctrl_pkg::MISC_IDX, 32'h84);
    wchk("sec", 5, 1'b1, 20);
    wreg(clock_ctrl_pkg::MISC_IDX, 32'h81);
    wchk("sec", 5, 1'b0, 20);
    @(posedge pclk);
    reference_select_pin <= 1'b1;
    wchk("sec", 5, 1'b1, 20);
    @(posedge pclk);
    reference_select_pin <= 1'b0;
    wchk("sec", 5, 1'b0, 20);
    wreg(clock_ctrl_pkg::VCOCTL_IDX, 32'h2);
    wchk("cal", 7, 1'b1, 10);
    wchk("cal", 7, 1'b0, 600);
    wreg(clock_ctrl_pkg::VCOCTL_IDX, 32'h2);
    repeat (20) @(negedge pclk);
    chk("cal", {31'h0, cal_busy}, 32'h0);
    wreg(clock_ctrl_pkg::VCOCTL_IDX, 32'h0);
    wreg(clock_ctrl_pkg::VCOCTL_IDX, 32'h2);
    wchk("cal", 7, 1'b1, 10);
    stop_test();
  end
endmodule // reference_switchover_and_dividers_tb_top
bind reference_switchover_and_dividers reference_switchover_and_dividers_assertions chk_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .oscillator_input,
  .input_loop_pfd_ref, .input_loop_pfd_fb, .output_loop_pfd_fb, .vco_div_pulse,
  .secondary_active, .holdover, .cp_tristate, .cp_half_supply, .cal_busy);
`default_nettype wire
